// ===== ext_read_stream_command_exec_tb_top.sv
// Self-checking bench for the read command executor with a host model.
// Assumes the constants header on the include path; the bench plays the media engine.
`timescale 1ns/1ns
`include "rsx_consts.vh"
module ext_read_stream_command_exec_tb_top;
  reg clk_i = 1'h0, resetn_i = 1'h0, cmd_wr_i = 1'h0, med_valid_i = 1'h0, med_last_i = 1'h0;
  reg reg_wr_i = 1'h0, reg_rd_i = 1'h0, rd_q = 1'h0, stall = 1'h0;
  reg [7:0] cmd_op_i = 8'h00, feat_cur_i = 8'h00, feat_prev_i = 8'h00, cnt_cur_i = 8'h00;
  reg [7:0] cnt_prev_i = 8'h00, med_err_i = 8'h00, reg_wdata_i = 8'h00;
  reg [23:0] lba_cur_i = 24'h0, lba_prev_i = 24'h0;
  reg [15:0] med_data_i = 16'h0;
  reg [3:0] reg_addr_i = 4'h0;
  reg [47:0] lba;
  wire host_ready_i, host_valid_o, med_start_o, med_urgent_o, med_ns_o, med_resume_o;
  wire med_stop_o, intrq_o;
  wire [7:0] device_i, reg_rdata_o;
  wire [15:0] host_data_o;
  wire [47:0] med_lba_o;
  wire [16:0] med_count_o;
  wire [2:0] med_stream_o;
  integer bad_count = 0, check_count = 0, n;
  logic [15:0] wq[$];
  logic [7:0] rq[$];
  logic [64:0] mq[$];
  rsx_cmd_exec dut (.*);
  rsx_host_model u_host (.clk_i(clk_i), .resetn_i(resetn_i), .stall_i(stall),
    .host_ready_o(host_ready_i), .device_o(device_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic miss(input logic [64:0] g, input logic [64:0] e);
    check_count = check_count + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    miss({49'h0, g}, {49'h0, e});
  endtask
  task automatic chk_r(input logic [7:0] g, input logic [7:0] e);
    miss({57'h0, g}, {57'h0, e});
  endtask
  task automatic chk_m(input logic [64:0] g, input logic [64:0] e);
    miss(g, e);
  endtask
  // Results are compared in the order they were promised.
  always @(posedge clk_i) begin
    rd_q <= reg_rd_i;
    if (rd_q === 1'h1) chk_r(reg_rdata_o, rq.pop_front());
    if (host_valid_o === 1'h1 && host_ready_i === 1'h1) chk_w(host_data_o, wq.pop_front());
    if (med_start_o === 1'h1) chk_m({med_lba_o, med_count_o}, mq.pop_front());
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] fc, input logic [7:0] fp,
    input logic [15:0] cnt, input logic ok);
    if (ok) mq.push_back({lba, cnt == 16'h0000 ? 17'h10000 : {1'h0, cnt}});
    @(posedge clk_i);
    cmd_wr_i <= 1'h1;
    cmd_op_i <= op;
    feat_cur_i <= fc;
    feat_prev_i <= fp;
    {cnt_prev_i, cnt_cur_i} <= cnt;
    {lba_prev_i, lba_cur_i} <= lba;
    @(posedge clk_i);
    cmd_wr_i <= 1'h0;
  endtask
  // The data line shows the inverse of the last word once released.
  task automatic sector(input logic [7:0] err);
    integer i;
    logic [15:0] d;
    for (i = 0; i < 4; i = i + 1) begin
      d = $urandom;
      wq.push_back(d);
      med_valid_i <= 1'h1;
      med_data_i <= d;
      med_last_i <= (i == 3);
      med_err_i <= (i == 3) ? err : 8'h00;
      do @(posedge clk_i); while (host_valid_o === 1'h1 && host_ready_i !== 1'h1);
    end
    med_valid_i <= 1'h0;
    med_last_i <= 1'h0;
    med_data_i <= ~d;
  endtask
  task automatic wait_irq;
    n = 0;
    do begin
      @(posedge clk_i);
      n = n + 1;
    end while (intrq_o !== 1'h1 && n < 9000);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test;
  end
  initial begin
    void'($urandom(17933));
    lba = {$urandom, $urandom} & 48'hFFFF_FFFF_FFF0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'h1;
    rd(`RSX_A_STATUS, 8'h40);
    rd(`RSX_A_ERROR, 8'h00);
    rd(4'hF, 8'h00);
    $display("test reset done");
    stall <= 1'h1;
    cmd(`RSX_OP_READ_EXT, 8'h00, 8'h00, 16'h0002, 1'h1);
    sector(8'h00);
    sector(8'h00);
    wait_irq;
    rd(`RSX_A_STATUS, 8'h40);
    $display("test sector read done");
    cmd(`RSX_OP_READ_EXT, 8'h00, 8'h00, 16'h0003, 1'h1);
    sector(8'h40);
    wait_irq;
    chk_r({7'h0, n < 50}, 8'h01);
    rd(`RSX_A_STATUS, 8'h41);
    rd(`RSX_A_ERROR, 8'h40);
    $display("test failing sector done");
    cmd(`RSX_OP_STREAM_DMA, 8'hF5, 8'h00, 16'h0003, 1'h1);
    sector(8'h00);
    sector(8'h40);
    sector(8'h00);
    wait_irq;
    rd(`RSX_A_STATUS, 8'h60);
    rd(`RSX_A_ERROR, 8'h00);
    rd(`RSX_A_ELOG, 8'h40);
    rd(`RSX_A_LBA_LO, lba[7:0] + 8'h01);
    rd(`RSX_A_SECT_CNT, 8'h01);
    wr(`RSX_A_HOB, 8'h01);
    rd(`RSX_A_LBA_LO, lba[31:24]);
    wr(`RSX_A_HOB, 8'h00);
    $display("test continuous error done");
    cmd(8'h20, 8'h00, 8'h00, 16'h0001, 1'h0);
    cmd(`RSX_OP_STREAM_DMA, 8'h01, 8'h01, 16'h0000, 1'h1);
    wait_irq;
    chk_r({7'h0, n > 2480 && n < 2520}, 8'h01);
    rd(`RSX_A_STATUS, 8'h41);
    rd(`RSX_A_ERROR, 8'h01);
    $display("test minimum limit done");
    wr(`RSX_A_UNIT, 8'hC8);
    cmd(`RSX_OP_STREAM_DMA, 8'hC0, 8'h01, 16'h0000, 1'h1);
    wait_irq;
    chk_r({7'h0, n > 4980 && n < 5020}, 8'h01);
    rd(`RSX_A_STATUS, 8'h60);
    rd(`RSX_A_ERROR, 8'h00);
    rd(`RSX_A_ELOG, 8'h01);
    $display("test continuous timeout done");
    wr(`RSX_A_DEFLIM, 8'h61);
    cmd(`RSX_OP_STREAM_DMA, 8'h43, 8'h00, 16'h0000, 1'h1);
    wait_irq;
    chk_r({7'h0, n > 4980 && n < 5020}, 8'h01);
    rd(`RSX_A_STATUS, 8'h60);
    rd(`RSX_A_ELOG, 8'h01);
    chk_r({7'h0, wq.size() == 0}, 8'h01);
    $display("test default limit done");
    end_of_test;
  end
endmodule // ext_read_stream_command_exec_tb_top

// ===== rsx_cmd_exec.v
// Command executor for the 48-bit sector read and the streaming DMA read.
// Assumes a media engine that hands sector words with per-sector error tags on clk_i.
// Contract
// (R1) Opcode 24h reads 1 to 65,536 sectors; zero count means 65,536.
// (R2) Sector read data leaves as 16-bit words, one per transfer.
// (R3) Uncorrectable error ends the sector read at the failing sector.
// (R4) Host sets device bit 6 on the sector read; bits 3:0 reserved.
// (R5) Opcode 2Ah streams 1 to 65536 sectors; zero count means 65536.
// (R6) Feature byte decodes urgent, continuous, not-sequential, error-resume and stream_identifier.
// (R7) Continuous clear selects the normal streaming mode.
// (R8) Continuous set: errors never stop; finish with stream error, no error bit.
// (R9) Continuous set and limit expired: halt with stream error and timeout logged.
// (R10) Always try to deliver the full amount within the time limit.
// (R11) Urgent set: finish fast, and always inside the time limit.
// (R12) Host may flag that the next same-stream read is not sequential.
// (R13) Error-resume starts at last error address; recovery may continue there. The code sends the command address, with med_resume_o set from the feature bit.
// (R14) Time limit in microseconds is previous feature byte times unit words.
// (R15) Zero byte uses the stream default; zero default means no limit.
// (R16) Limit is timed from command write until the completion interrupt.
// (R17) A limit below the device minimum is raised to the minimum.
// (R18) Count is current byte low, previous byte high; zero means 65,536.
// (R19) Address: current bytes give bits 23:0, previous bytes bits 47:24.
// (R20) On stream error return first bad address and bad-sector run length.
// (R21) Timeout bit 0 of the error register is set when the limit passes.
// (R22) Continuous set: listed errors set stream error, clear error, go to log.
// (R23) Continuous clear: an error ends the command with error bits reported.
`timescale 1ns/1ns
`include "rsx_consts.vh"
module rsx_cmd_exec (
  // Clock and reset.
  input wire clk_i,
  input wire resetn_i,
  // Host command block write: current and previous bytes per field.
  input wire cmd_wr_i,
  input wire [7:0] cmd_op_i,
  input wire [7:0] feat_cur_i,
  input wire [7:0] feat_prev_i,
  input wire [7:0] cnt_cur_i,
  input wire [7:0] cnt_prev_i,
  input wire [23:0] lba_cur_i,
  input wire [23:0] lba_prev_i,
  input wire [7:0] device_i,
  // Media engine word stream with error tags.
  input wire med_valid_i,
  input wire [15:0] med_data_i,
  input wire med_last_i,
  input wire [7:0] med_err_i,
  // Host data port.
  input wire host_ready_i,
  output reg host_valid_o,
  output reg [15:0] host_data_o,
  // Media engine request.
  output reg med_start_o,
  output reg [47:0] med_lba_o,
  output reg [16:0] med_count_o,
  output reg [2:0] med_stream_o,
  output reg med_urgent_o,
  output reg med_ns_o,
  output reg med_resume_o,
  output reg med_stop_o,
  // Completion interrupt.
  output reg intrq_o,
  // Register port.
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o
);
  localparam S_IDLE = 3'b001;
  localparam S_RUN = 3'b010;
  localparam S_DONE = 3'b100;

  reg [2:0] state_r;
  reg [7:0] err_r;
  reg [7:0] stat_r;
  reg [7:0] elog_r;
  reg [47:0] bad_lba_r;
  reg [15:0] bad_cnt_r;
  reg bad_seen_r;
  reg bad_run_r;
  reg [16:0] sect_left_r;
  reg [47:0] cur_lba_r;
  reg rc_r;
  reg stream_r;
  reg hob_r;
  reg [15:0] unit_r;
  reg [7:0] deflim_r [0:7];
  reg [31:0] limit_r;
  reg [31:0] us_r;
  reg [4:0] div_r;
  reg limit_on_r;
  reg [2:0] sid_w;
  reg [31:0] lim_w;
  integer i;

  // Zero count encodes the full 65,536 sectors. [R1] [R5] [R18]
  function [16:0] sect_count;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if ({hi, lo} == 16'h0000) begin
        sect_count = 17'h10000;
      end else begin
        sect_count = {1'b0, hi, lo};
      end
    end
  endfunction

  // Limit from byte and unit, with default fallback and minimum clamp. [R14] [R15] [R17]
  always @* begin
    sid_w = feat_cur_i[2:0];
    if (feat_prev_i != 8'h00) begin
      // The product is kept at its full 24 bits so large units do not wrap.
      lim_w = {8'h00, {16'h0000, feat_prev_i} * {8'h00, unit_r}};
    end else begin
      lim_w = {8'h00, {16'h0000, deflim_r[sid_w]} * {8'h00, unit_r}};
    end
    if (lim_w != 32'h0000_0000 && lim_w < `RSX_MIN_LIMIT_US) begin
      lim_w = `RSX_MIN_LIMIT_US;
    end
  end

  wire words_ok = med_valid_i && (!host_valid_o || host_ready_i);
  wire sect_err = words_ok && med_last_i && (med_err_i != 8'h00);
  wire timed_out = limit_on_r && (us_r >= limit_r);
  wire last_sect = words_ok && med_last_i && (sect_left_r == 17'h00001);

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= S_IDLE;
      err_r <= 8'h00;
      stat_r <= 8'h40;
      elog_r <= 8'h00;
      bad_lba_r <= 48'h0000_0000_0000;
      bad_cnt_r <= 16'h0000;
      bad_seen_r <= 1'b0;
      bad_run_r <= 1'b0;
      sect_left_r <= 17'h00000;
      cur_lba_r <= 48'h0000_0000_0000;
      rc_r <= 1'b0;
      stream_r <= 1'b0;
      hob_r <= 1'b0;
      unit_r <= `RSX_UNIT_US;
      for (i = 0; i < 8; i = i + 1) begin
        deflim_r[i] <= 8'h00;
      end
      limit_r <= 32'h0000_0000;
      us_r <= 32'h0000_0000;
      div_r <= 5'h00;
      limit_on_r <= 1'b0;
      host_valid_o <= 1'b0;
      host_data_o <= 16'h0000;
      med_start_o <= 1'b0;
      med_lba_o <= 48'h0000_0000_0000;
      med_count_o <= 17'h00000;
      med_stream_o <= 3'h0;
      med_urgent_o <= 1'b0;
      med_ns_o <= 1'b0;
      med_resume_o <= 1'b0;
      med_stop_o <= 1'b0;
      intrq_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      med_start_o <= 1'b0;
      med_stop_o <= 1'b0;
      intrq_o <= 1'b0;
      if (host_valid_o && host_ready_i) begin
        host_valid_o <= 1'b0;
      end
      if (reg_wr_i) begin
        case (reg_addr_i)
          `RSX_A_HOB: hob_r <= reg_wdata_i[0];
          `RSX_A_UNIT: unit_r <= {8'h00, reg_wdata_i};
          `RSX_A_DEFLIM: deflim_r[reg_wdata_i[7:5]] <= {3'h0, reg_wdata_i[4:0]};
          default: ;
        endcase
      end
      if (reg_rd_i) begin
        case (reg_addr_i)
          `RSX_A_ERROR: reg_rdata_o <= err_r;
          `RSX_A_STATUS: reg_rdata_o <= stat_r;
          `RSX_A_ELOG: reg_rdata_o <= elog_r;
          `RSX_A_HOB: reg_rdata_o <= {7'h00, hob_r};
          // First bad address and run length, split by the byte select. [R20]
          `RSX_A_SECT_CNT: reg_rdata_o <= hob_r ? bad_cnt_r[15:8] : bad_cnt_r[7:0];
          `RSX_A_LBA_LO: reg_rdata_o <= hob_r ? bad_lba_r[31:24] : bad_lba_r[7:0];
          `RSX_A_LBA_MID: reg_rdata_o <= hob_r ? bad_lba_r[39:32] : bad_lba_r[15:8];
          `RSX_A_LBA_HI: reg_rdata_o <= hob_r ? bad_lba_r[47:40] : bad_lba_r[23:16];
          default: reg_rdata_o <= 8'h00;
        endcase
      end
      case (state_r)
        S_IDLE, S_DONE: begin
          // Host is trusted to set LBA mode bit; device bits 3:0 are ignored. [R4]
          if (cmd_wr_i && (cmd_op_i == `RSX_OP_READ_EXT || cmd_op_i == `RSX_OP_STREAM_DMA)) begin
            state_r <= S_RUN;
            stream_r <= (cmd_op_i == `RSX_OP_STREAM_DMA);
            rc_r <= (cmd_op_i == `RSX_OP_STREAM_DMA) && feat_cur_i[`RSX_FT_RC]; // [R7]
            sect_left_r <= sect_count(cnt_cur_i, cnt_prev_i); // [R1] [R5] [R18]
            cur_lba_r <= {lba_prev_i, lba_cur_i}; // [R19]
            med_lba_o <= {lba_prev_i, lba_cur_i}; // [R19] [R13]
            med_count_o <= sect_count(cnt_cur_i, cnt_prev_i);
            med_start_o <= 1'b1;
            // Stream selection and hints go to the media engine. [R6] [R11] [R12] [R13]
            med_stream_o <= feat_cur_i[2:0];
            med_urgent_o <= feat_cur_i[`RSX_FT_URG];
            med_ns_o <= feat_cur_i[`RSX_FT_NS];
            med_resume_o <= feat_cur_i[`RSX_FT_HSE];
            // Timing begins at the command write. [R16]
            limit_on_r <= (cmd_op_i == `RSX_OP_STREAM_DMA) && (lim_w != 32'h0000_0000);
            limit_r <= lim_w;
            us_r <= 32'h0000_0000;
            div_r <= 5'h00;
            err_r <= 8'h00;
            elog_r <= 8'h00;
            bad_seen_r <= 1'b0;
            bad_run_r <= 1'b0;
            bad_cnt_r <= 16'h0000;
            stat_r <= 8'h80 | 8'h40;
          end
        end
        S_RUN: begin
          if (div_r == `RSX_US_LAST) begin
            div_r <= 5'h00;
            us_r <= us_r + 32'h0000_0001;
          end else begin
            div_r <= div_r + 5'h01;
          end
          if (words_ok) begin
            host_valid_o <= 1'b1; // [R2]
            host_data_o <= med_data_i;
          end
          if (words_ok && med_last_i) begin
            sect_left_r <= sect_left_r - 17'h00001;
            cur_lba_r <= cur_lba_r + 48'h0000_0000_0001;
            if (sect_err) begin
              if (!bad_seen_r) begin
                bad_lba_r <= cur_lba_r;
              end
              bad_seen_r <= 1'b1;
              bad_run_r <= 1'b1;
              if (bad_run_r || !bad_seen_r) begin
                bad_cnt_r <= bad_cnt_r + 16'h0001;
              end
            end else begin
              bad_run_r <= 1'b0;
            end
          end
          if (timed_out && rc_r) begin
            // Expiry halts, reported through the log. [R9] [R21] [R22]
            state_r <= S_DONE;
            med_stop_o <= 1'b1;
            intrq_o <= 1'b1;
            elog_r <= elog_r | (8'h01 << `RSX_ER_COMPLETION_TIMEOUT);
            stat_r <= 8'h40 | (8'h01 << `RSX_ST_SE);
          end else if (timed_out) begin
            state_r <= S_DONE;
            med_stop_o <= 1'b1;
            intrq_o <= 1'b1;
            err_r <= 8'h01 << `RSX_ER_COMPLETION_TIMEOUT; // [R21] [R23]
            stat_r <= 8'h40 | (8'h01 << `RSX_ST_ERR);
          end else if (sect_err && !rc_r) begin
            // Stop at the failing sector with the error shown directly. [R3] [R23]
            state_r <= S_DONE;
            med_stop_o <= 1'b1;
            intrq_o <= 1'b1;
            err_r <= med_err_i & `RSX_ERR_MASK;
            stat_r <= 8'h40 | (8'h01 << `RSX_ST_ERR);
          end else if (sect_err || last_sect) begin
            // Continuous mode keeps going; errors only collect in the log. [R8] [R10] [R22]
            if (sect_err) begin
              elog_r <= elog_r | (med_err_i & `RSX_ERR_MASK);
            end
            if (last_sect) begin
              state_r <= S_DONE;
              intrq_o <= 1'b1;
              stat_r <= 8'h40 | ((bad_seen_r || sect_err) ? (8'h01 << `RSX_ST_SE) : 8'h00);
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // rsx_cmd_exec

// ===== rsx_cmd_exec_assertions.sv
// Concurrent checks on the ports of the read command executor.
// Assumes one clock domain and the constants header on the include path.
`timescale 1ns/1ns
`include "rsx_consts.vh"
module rsx_cmd_exec_chk (
  // Clock, reset and command block.
  input wire clk_i, input wire resetn_i, input wire cmd_wr_i, input wire [7:0] cmd_op_i,
  input wire [7:0] feat_cur_i, input wire [7:0] cnt_cur_i, input wire [7:0] cnt_prev_i,
  input wire [23:0] lba_cur_i, input wire [23:0] lba_prev_i,
  // Word flow.
  input wire med_valid_i, input wire [15:0] med_data_i, input wire host_ready_i,
  input wire host_valid_o, input wire [15:0] host_data_o,
  // Media request and completion.
  input wire med_start_o, input wire [47:0] med_lba_o, input wire [16:0] med_count_o,
  input wire [2:0] med_stream_o, input wire med_urgent_o, input wire med_ns_o,
  input wire med_resume_o, input wire med_stop_o, input wire intrq_o
);
  reg idle_r;
  wire op_ok = cmd_op_i == `RSX_OP_READ_EXT || cmd_op_i == `RSX_OP_STREAM_DMA;
  wire [16:0] cnt_exp = {cnt_prev_i, cnt_cur_i} == 16'h0000 ? 17'h10000 :
    {1'h0, cnt_prev_i, cnt_cur_i};
  // Tracks whether a command is running, so refused writes can be told apart.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) idle_r <= 1'h1;
    else if (intrq_o) idle_r <= 1'h1;
    else if (cmd_wr_i && op_ok) idle_r <= 1'h0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_cmd; cmd_wr_i && idle_r && op_ok; endsequence
  sequence s_take; med_valid_i && (!host_valid_o || host_ready_i) && !idle_r; endsequence
  a_start_next: assert property (s_cmd |=> med_start_o)
    else $error("no media start after command");
  a_other_op: assert property (cmd_wr_i && idle_r && !op_ok |=> !med_start_o)
    else $error("unknown opcode started a read");
  a_count_build: assert property (s_cmd |=> med_count_o == $past(cnt_exp))
    else $error("sector count wrong");
  a_addr_build: assert property (s_cmd |=> med_lba_o == $past({lba_prev_i, lba_cur_i}))
    else $error("start address wrong");
  a_feat_decode: assert property (s_cmd and cmd_op_i == `RSX_OP_STREAM_DMA |=>
    med_stream_o == $past(feat_cur_i[2:0]) && med_urgent_o == $past(feat_cur_i[`RSX_FT_URG])
    && med_ns_o == $past(feat_cur_i[`RSX_FT_NS]) && med_resume_o == $past(feat_cur_i[`RSX_FT_HSE]))
    else $error("feature decode wrong");
  a_word_pass: assert property (s_take |=> host_valid_o && host_data_o == $past(med_data_i))
    else $error("media word not passed on");
  a_word_hold: assert property (host_valid_o && !host_ready_i |=>
    host_valid_o && $stable(host_data_o))
    else $error("host word changed while stalled");
  a_stop_ends: assert property (med_stop_o |-> intrq_o)
    else $error("media stop without completion");
  a_irq_pulse: assert property (intrq_o |=> !intrq_o)
    else $error("completion pulse too long");
  a_irq_busy: assert property (intrq_o |-> !idle_r)
    else $error("completion without command");
endmodule // rsx_cmd_exec_chk
bind rsx_cmd_exec rsx_cmd_exec_chk u_chk (.*);

// ===== rsx_consts.vh
// Constants for the extended and streaming read command executor.
// Assumes inclusion by rsx_cmd_exec.v, the assertion module and the bench; definitions only.
`ifndef RSX_CONSTS_VH
`define RSX_CONSTS_VH
`define RSX_OP_READ_EXT 8'h24
`define RSX_OP_STREAM_DMA 8'h2A
`define RSX_FT_URG 7
`define RSX_FT_RC 6
`define RSX_FT_NS 5
`define RSX_FT_HSE 4
`define RSX_DEV_LBA 6
`define RSX_ER_CRC 7
`define RSX_ER_UNC 6
`define RSX_ER_IDN 4
`define RSX_ER_ABT 2
`define RSX_ER_COMPLETION_TIMEOUT 0
`define RSX_ST_BSY 7
`define RSX_ST_RDY 6
`define RSX_ST_SE 5
`define RSX_ST_DRQ 3
`define RSX_ST_ERR 0
`define RSX_ERR_MASK 8'hD5
`define RSX_CLK_MHZ 25
`define RSX_US_DIV 25
`define RSX_US_LAST 5'h18
`define RSX_MIN_LIMIT_US 32'h0000_0064
`define RSX_UNIT_US 16'h0001
`define RSX_A_ERROR 4'h1
`define RSX_A_STATUS 4'h7
`define RSX_A_SECT_CNT 4'h2
`define RSX_A_LBA_LO 4'h3
`define RSX_A_LBA_MID 4'h4
`define RSX_A_LBA_HI 4'h5
`define RSX_A_HOB 4'h8
`define RSX_A_ELOG 4'h9
`define RSX_A_UNIT 4'hA
`define RSX_A_DEFLIM 4'hB
`endif

// ===== rsx_host_model.sv
// Host side model: takes data words with random stalls, drives the device byte.
// Assumes the bench supplies clock, reset and a stall enable.
`timescale 1ns/1ns
module rsx_host_model (
  // Clock, reset and control.
  input wire clk_i,
  input wire resetn_i,
  input wire stall_i,
  // Data port and command block field.
  output reg host_ready_o,
  output wire [7:0] device_o
);
  assign device_o = 8'h40;
  // Random stalls make the executor hold words, as a real host would.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) host_ready_o <= 1'h0;
    else host_ready_o <= !stall_i || ($urandom % 3 != 0);
  end
endmodule // rsx_host_model
